// *** common/tpb0_pkg.sv ***
package tpb0_pkg;

  // channel operating mode, static configuration from the channel core
  typedef enum logic [1:0] {
    MODE_NIBBLE,
    MODE_SERIAL,
    MODE_ATM,
    MODE_PACKET
  } tpb0_mode_e;

  // kind of word pushed into the data fifo
  typedef enum logic [1:0] {
    KIND_NIBBLE,
    KIND_FLOW,
    KIND_PACKET,
    KIND_NONE
  } tpb0_kind_e;

  localparam int unsigned WORD_W          = 8;
  localparam int unsigned NIBBLE_W        = 4;
  localparam int unsigned FLOW_BITS       = 4;
  localparam int unsigned UPPER_W         = 7;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam int unsigned SYNC_LAT        = 2;
  localparam int unsigned HALF_PERIOD_CYC = 2;
  localparam int unsigned NIBBLES_PER_FRM = 16;

endpackage

// *** hdl/tpb0_port.sv ***
`timescale 1ns/10ps

module tpb0_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    wr_nxt;
  logic [AW-1:0]    rd_r;
  logic [AW-1:0]    rd_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_nxt  = push ? inc_ptr(wr_r) : wr_r;
    rd_nxt  = pop ? inc_ptr(rd_r) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; valid words are tracked by the count
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

module tpb0_port #(
  parameter int unsigned HALF_CYC   = tpb0_pkg::HALF_PERIOD_CYC,
  parameter int unsigned FRM_NIBS   = tpb0_pkg::NIBBLES_PER_FRM,
  parameter int unsigned FIFO_DEPTH = tpb0_pkg::FIFO_DEPTH
) (
  input  wire logic                                 MCLK,
  input  wire logic                                 RST_N,
  input  wire tpb0_pkg::tpb0_mode_e                 MODE,
  input  wire logic                                 TX_DATA_BIT0,
  input  wire logic [tpb0_pkg::UPPER_W-1:0]         TX_DATA_UPPER,
  output logic                                      PAYLOAD_NIBBLE_CLOCK,
  output logic                                      FLOW_FIELD_BIT_CLOCK,
  output logic                                      FLOW_FIELD_MSB_MARKER,
  output logic                                      PACKET_BYTE_CLOCK,
  output logic                                      NIBBLE_FRAME_BOUNDARY_PULSE,
  output logic                                      WORD_VALID,
  input  wire logic                                 WORD_READY,
  output logic [tpb0_pkg::WORD_W-1:0]               WORD_DATA,
  output tpb0_pkg::tpb0_kind_e                      WORD_KIND
);
  localparam int unsigned WORD_W = tpb0_pkg::WORD_W;
  localparam int unsigned FW     = WORD_W + 2;
  localparam int unsigned HW     = $clog2(HALF_CYC + 1);
  localparam int unsigned NW     = $clog2(FRM_NIBS + 1);

  logic [WORD_W-1:0]      sync1_r;
  logic [WORD_W-1:0]      sync2_r;
  logic [HW-1:0]          div_r;
  logic [HW-1:0]          div_nxt;
  logic                   lclk_r;
  logic                   lclk_nxt;
  logic [tpb0_pkg::SYNC_LAT-1:0] rise_r;
  logic [tpb0_pkg::SYNC_LAT-1:0] rise_nxt;
  logic [tpb0_pkg::SYNC_LAT-1:0] fall_r;
  logic [tpb0_pkg::SYNC_LAT-1:0] fall_nxt;
  logic [NW-1:0]          nib_cnt_r;
  logic [NW-1:0]          nib_cnt_nxt;
  logic [1:0]             bit_cnt_r;
  logic [1:0]             bit_cnt_nxt;
  logic [tpb0_pkg::FLOW_BITS-1:0] flow_r;
  logic [tpb0_pkg::FLOW_BITS-1:0] flow_nxt;
  logic                   bound_r;
  logic                   bound_nxt;
  logic                   marker_r;
  logic                   marker_nxt;
  tpb0_pkg::tpb0_mode_e   mode_r;
  logic                   push;
  logic [FW-1:0]          push_word;
  logic                   fifo_ready;
  logic [FW-1:0]          pop_word;
  logic                   run;
  logic                   fall_now;
  logic                   rise_now;

  // two flip-flops on every pin input from the terminal equipment
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {TX_DATA_UPPER, TX_DATA_BIT0};
      sync2_r <= sync1_r;
    end
  end

  // link clock divider; halts while fifo is full or a sample is in flight
  assign run      = (MODE != tpb0_pkg::MODE_SERIAL) && (MODE == mode_r) && fifo_ready
                    && (rise_r == '0) && (fall_r == '0);
  assign rise_now = rise_r[tpb0_pkg::SYNC_LAT-1];
  assign fall_now = fall_r[tpb0_pkg::SYNC_LAT-1];

  always_comb
  begin
    div_nxt   = div_r;
    lclk_nxt  = lclk_r;
    rise_nxt  = {rise_r[tpb0_pkg::SYNC_LAT-2:0], 1'b0};
    fall_nxt  = {fall_r[tpb0_pkg::SYNC_LAT-2:0], 1'b0};
    if (MODE != mode_r || MODE == tpb0_pkg::MODE_SERIAL)
    begin
      div_nxt  = '0;
      lclk_nxt = 1'b0;
      rise_nxt = '0;
      fall_nxt = '0;
    end
    else if (run)
    begin
      if (div_r == HW'(HALF_CYC - 1))
      begin
        div_nxt     = '0;
        lclk_nxt    = !lclk_r;
        rise_nxt[0] = !lclk_r;
        fall_nxt[0] = lclk_r;
      end
      else
      begin
        div_nxt = div_r + 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      div_r  <= '0;
      lclk_r <= 1'b0;
      rise_r <= '0;
      fall_r <= '0;
      mode_r <= tpb0_pkg::MODE_SERIAL;
    end
    else
    begin
      div_r  <= div_nxt;
      lclk_r <= lclk_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      mode_r <= MODE;
    end
  end

  // only the clock of the selected function runs
  assign PAYLOAD_NIBBLE_CLOCK = lclk_r && (mode_r == tpb0_pkg::MODE_NIBBLE);
  assign FLOW_FIELD_BIT_CLOCK = lclk_r && (mode_r == tpb0_pkg::MODE_ATM);
  assign PACKET_BYTE_CLOCK    = lclk_r && (mode_r == tpb0_pkg::MODE_PACKET);

  // capture, framing and flow-field assembly
  always_comb
  begin
    nib_cnt_nxt = nib_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    flow_nxt    = flow_r;
    push        = 1'b0;
    push_word   = {tpb0_pkg::KIND_NONE, {WORD_W{1'b0}}};
    if (MODE != mode_r)
    begin
      nib_cnt_nxt = '0;
      bit_cnt_nxt = '0;
    end
    else
    begin
      case (mode_r)
        tpb0_pkg::MODE_NIBBLE:
        begin
          if (fall_now)
          begin
            push        = 1'b1;
            push_word   = {tpb0_pkg::KIND_NIBBLE, 4'h0, sync2_r[tpb0_pkg::NIBBLE_W-1:0]};
            nib_cnt_nxt = (nib_cnt_r == NW'(FRM_NIBS - 1)) ? '0 : nib_cnt_r + 1'b1;
          end
        end
        tpb0_pkg::MODE_ATM:
        begin
          if (rise_now)
          begin
            flow_nxt    = {flow_r[tpb0_pkg::FLOW_BITS-2:0], sync2_r[0]};
            bit_cnt_nxt = bit_cnt_r + 1'b1;
            if (bit_cnt_r == 2'(tpb0_pkg::FLOW_BITS - 1))
            begin
              push      = 1'b1;
              push_word = {tpb0_pkg::KIND_FLOW, 4'h0, flow_r[tpb0_pkg::FLOW_BITS-2:0], sync2_r[0]};
            end
          end
        end
        tpb0_pkg::MODE_PACKET:
        begin
          if (rise_now)
          begin
            push      = 1'b1;
            push_word = {tpb0_pkg::KIND_PACKET, sync2_r};
          end
        end
        default:
        begin
          push = 1'b0;
        end
      endcase
    end
    bound_nxt  = (mode_r == tpb0_pkg::MODE_NIBBLE) && (MODE == mode_r)
                 && (nib_cnt_nxt == NW'(FRM_NIBS - 1));
    marker_nxt = (mode_r == tpb0_pkg::MODE_ATM) && (MODE == mode_r) && (bit_cnt_nxt == '0);
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      nib_cnt_r <= '0;
      bit_cnt_r <= '0;
      flow_r    <= '0;
      bound_r   <= 1'b0;
      marker_r  <= 1'b0;
    end
    else
    begin
      nib_cnt_r <= nib_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      flow_r    <= flow_nxt;
      bound_r   <= bound_nxt;
      marker_r  <= marker_nxt;
    end
  end

  assign NIBBLE_FRAME_BOUNDARY_PULSE = bound_r;
  assign FLOW_FIELD_MSB_MARKER       = marker_r;

  tpb0_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (WORD_VALID),
    .out_ready (WORD_READY),
    .out_data  (pop_word)
  );

  assign WORD_DATA = pop_word[WORD_W-1:0];
  assign WORD_KIND = tpb0_pkg::tpb0_kind_e'(pop_word[FW-1:WORD_W]);
endmodule

// *** dv/tpb0_props.sv ***
`timescale 1ns/10ps
module tpb0_props (
  input wire logic                 MCLK,
  input wire logic                 RST_N,
  input wire tpb0_pkg::tpb0_mode_e MODE,
  input wire logic                 PAYLOAD_NIBBLE_CLOCK,
  input wire logic                 FLOW_FIELD_BIT_CLOCK,
  input wire logic                 FLOW_FIELD_MSB_MARKER,
  input wire logic                 PACKET_BYTE_CLOCK,
  input wire logic                 NIBBLE_FRAME_BOUNDARY_PULSE,
  input wire logic                 WORD_VALID,
  input wire tpb0_pkg::tpb0_kind_e WORD_KIND
);
  logic [2:0] rc_r, rc_nxt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // last flow clock level and count of its rises
  always_comb rc_nxt = {FLOW_FIELD_BIT_CLOCK, rc_r[1:0] + 2'(FLOW_FIELD_BIT_CLOCK & ~rc_r[2])};
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      rc_r <= '0;
    else
      rc_r <= rc_nxt;
  quiet_serial_a:
    assert property (MODE == tpb0_pkg::MODE_SERIAL |-> !WORD_VALID) else $error("serial push");
  byte_gate_a:
    assert property (PACKET_BYTE_CLOCK |-> MODE == tpb0_pkg::MODE_PACKET) else $error("byte clock");
  flow_kind_a:
    assert property (WORD_VALID && MODE == tpb0_pkg::MODE_ATM |-> WORD_KIND == tpb0_pkg::KIND_FLOW) else $error("kind");
  byte_edge_a:
    assert property ($rose(PACKET_BYTE_CLOCK) && !WORD_VALID |-> ##[1:4] WORD_VALID) else $error("byte push");
  nib_fall_a:
    assert property ($fell(PAYLOAD_NIBBLE_CLOCK) && !WORD_VALID |-> ##[1:4] WORD_VALID) else $error("nibble push");
  nib_rise_a:
    assert property ($rose(PAYLOAD_NIBBLE_CLOCK) && !WORD_VALID |=> !WORD_VALID [*4]) else $error("early push");
  flow_msb_a:
    assert property (FLOW_FIELD_BIT_CLOCK && !rc_r[2] |-> FLOW_FIELD_MSB_MARKER == (rc_r[1:0] == 2'h0))
      else $error("msb marker");
  frame_mode_a:
    assert property (NIBBLE_FRAME_BOUNDARY_PULSE |-> MODE == tpb0_pkg::MODE_NIBBLE) else $error("frame pulse");
endmodule
bind tpb0_port tpb0_props tpb0_props_inst (.MCLK(MCLK), .RST_N(RST_N), .MODE(MODE),
  .PAYLOAD_NIBBLE_CLOCK(PAYLOAD_NIBBLE_CLOCK), .FLOW_FIELD_BIT_CLOCK(FLOW_FIELD_BIT_CLOCK),
  .FLOW_FIELD_MSB_MARKER(FLOW_FIELD_MSB_MARKER), .PACKET_BYTE_CLOCK(PACKET_BYTE_CLOCK),
  .NIBBLE_FRAME_BOUNDARY_PULSE(NIBBLE_FRAME_BOUNDARY_PULSE), .WORD_VALID(WORD_VALID), .WORD_KIND(WORD_KIND));

// *** dv/tpb0_term.sv ***
`timescale 1ns/10ps
module tpb0_term (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire tpb0_pkg::tpb0_mode_e mode,
  input  wire logic                 nclk,
  input  wire logic                 fclk,
  input  wire logic                 bclk,
  output logic                      bit0,
  output logic [6:0]                upper
);
  logic [7:0] s_r, s_nxt;
  logic [3:0] ck_r, ck_nxt;
  logic [3:0] fv;
  // data moves on the edge away from the sampling one
  always_comb
  begin
    s_nxt  = s_r + 8'(nclk & ~ck_r[2] | ~fclk & ck_r[1] | ~bclk & ck_r[0]);
    ck_nxt = {~ck_r[3], nclk, fclk, bclk};
    fv     = s_r[5:2] + 4'h9;
    bit0   = mode == tpb0_pkg::MODE_ATM ? fv[~s_r[1:0]] : s_r[0];
    upper  = s_r[7:1];
    if (mode == tpb0_pkg::MODE_SERIAL)
      bit0 = ck_r[3];
  end
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {s_r, ck_r} <= '0;
    else
      {s_r, ck_r} <= {s_nxt, ck_nxt};
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic                 clk;
  logic                 rst_n;
  logic                 rdy;
  logic                 b0;
  logic [6:0]           up;
  logic                 nclk, fclk, bclk, msb, fbp, vld;
  logic [7:0]           dat;
  logic [7:0]           d;
  tpb0_pkg::tpb0_mode_e mode;
  tpb0_pkg::tpb0_kind_e knd;
  tpb0_pkg::tpb0_kind_e k;
  int                   fails = 0;
  int                   n_checks = 0;
  int                   nfb = 0;
  tpb0_port #(.HALF_CYC(2), .FRM_NIBS(4)) tpb0_port_inst (.MCLK(clk), .RST_N(rst_n), .MODE(mode),
    .TX_DATA_BIT0(b0), .TX_DATA_UPPER(up), .PAYLOAD_NIBBLE_CLOCK(nclk), .FLOW_FIELD_BIT_CLOCK(fclk),
    .FLOW_FIELD_MSB_MARKER(msb), .PACKET_BYTE_CLOCK(bclk), .NIBBLE_FRAME_BOUNDARY_PULSE(fbp),
    .WORD_VALID(vld), .WORD_READY(rdy), .WORD_DATA(dat), .WORD_KIND(knd));
  tpb0_term tpb0_term_inst (.clk(clk), .rst_n(rst_n), .mode(mode), .nclk(nclk), .fclk(fclk),
    .bclk(bclk), .bit0(b0), .upper(up));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge fbp) nfb++;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic start(input tpb0_pkg::tpb0_mode_e m);
    #1 rst_n = 0;
    mode = m;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    nfb = 0;
  endtask
  task automatic get(output logic [7:0] dd, output tpb0_pkg::tpb0_kind_e kk);
    int i;
    i = 0;
    // look at the fifo head between edges; the pop happens on the next rising edge
    do
    begin
      @(negedge clk);
      i++;
    end
    while (!(vld && rdy) && i < 400);
    dd = dat;
    kk = knd;
    @(posedge clk);
    chk(8'(i < 400), 8'h01);
  endtask
  task automatic test_serial;
    start(tpb0_pkg::MODE_SERIAL);
    repeat (100) @(posedge clk);
    chk({4'h0, vld, nclk, fclk, bclk}, 8'h00);
    $display("serial test done");
  endtask
  task automatic test_nibble;
    start(tpb0_pkg::MODE_NIBBLE);
    for (int j = 1; j < 13; j++)
    begin
      get(d, k);
      chk({k, 2'h0, d[3:0]}, {tpb0_pkg::KIND_NIBBLE, 2'h0, 4'(j)});
    end
    chk(8'(nfb), 8'h03);
    $display("nibble test done");
  endtask
  task automatic test_flow;
    start(tpb0_pkg::MODE_ATM);
    repeat (3) @(negedge clk);
    chk({7'h0, msb}, 8'h01);
    for (int j = 9; j < 13; j++)
    begin
      get(d, k);
      chk({k, 2'h0, d[3:0]}, {tpb0_pkg::KIND_FLOW, 2'h0, 4'(j)});
    end
    $display("flow test done");
  endtask
  task automatic test_stall;
    int   r;
    logic p;
    start(tpb0_pkg::MODE_PACKET);
    rdy = 0;
    repeat (150) @(negedge clk);
    r = 0;
    p = bclk;
    repeat (40)
    begin
      @(negedge clk);
      r += int'(bclk !== p);
      p = bclk;
    end
    chk({7'(r), vld}, 8'h01);
    @(posedge clk);
    #1 rdy = 1;
    for (int j = 0; j < 8; j++)
    begin
      get(d, k);
      chk(d, 8'(j));
    end
    chk(8'(k), 8'(tpb0_pkg::KIND_PACKET));
    $display("stall test done");
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 0;
    rdy = 1;
    mode = tpb0_pkg::MODE_SERIAL;
    repeat (16) @(posedge clk);
    test_serial;
    test_nibble;
    test_flow;
    test_stall;
    final_report;
  end
  initial
  begin
    #250000;
    fails++;
    $display("ERROR %0t timeout", $time);
    final_report;
  end
endmodule
